//--- src/dsao_status.v
// drive status and alarm outputs: turn-limit mismatch, origin offset,
// fault, warning and motion-detect outputs
// assumes configuration arrives on plain ports from same-clock logic;
// panel key and sensor-on pulses come from same-clock logic too
`timescale 1ns/10ps
`include "dsao_defs.vh"
module dsao_status #(
   parameter PINS = 3,
   parameter DONE_CYCLES = `DSAO_DONE_CYCLES
) (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire [15:0] turn_limit_param,
   input wire [15:0] encoder_turn_limit,
   input wire [15:0] write_protect_setting,
   input wire turn_limit_write_function,
   input wire encoder_write_ack,
   input wire signed [31:0] origin_offset,
   input wire signed [31:0] encoder_position,
   input wire sensor_on_command,
   input wire other_error,
   input wire warning_condition,
   input wire fault_clear_command,
   input wire alarm_reset_key,
   input wire [13:0] motion_detect_level,
   input wire [13:0] motor_speed,
   input wire [3:0] caution_pin_assign,
   input wire [3:0] motion_pin_assign,
   output reg turn_limit_mismatch_alarm,
   output reg fault_output,
   output reg [15:0] encoder_write_data,
   output reg encoder_write_req,
   output reg write_done,
   output reg write_noop,
   output reg signed [31:0] machine_coord_position,
   output reg offset_applied,
   output reg error_latched,
   output wire [PINS-1:0] caution_pins,
   output wire [PINS-1:0] motion_pins
);
   // ==================================================
   // write sequencer states
   localparam ST_IDLE = 3'b001;
   localparam ST_WRITE = 3'b010;
   localparam ST_DONE = 3'b100;
   localparam [31:0] DONE_LAST = DONE_CYCLES - 1;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [31:0] done_cnt;
   reg [31:0] next_done_cnt;
   reg [15:0] next_write_data;
   reg next_write_req;
   reg next_write_done;
   reg next_write_noop;
   reg next_latched;
   reg next_fault;
   reg signed [31:0] next_coord;
   reg [15:0] limit_used;
   reg limit_taken;
   reg motion_level;
   wire [15:0] limit_now;
   wire mismatch;
   wire clear_req;
   wire offset_ok;
   wire [13:0] level_eff;
   wire signed [31:0] offset_eff;

   // ==================================================
   // limit in force is captured once, on the first enabled cycle after reset;
   // until then the live setting stands in, so no false mismatch follows reset
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         limit_used <= `DSAO_LIMIT_DEF;
         limit_taken <= 1'b0;
      end else if (ce && !limit_taken) begin
         limit_used <= turn_limit_param;
         limit_taken <= 1'b1;
      end
   end
   assign limit_now = limit_taken ? limit_used : turn_limit_param;
   // the parameter copy only becomes valid after a reset, so a changed and written limit keeps the alarm until then
   assign mismatch = (limit_now != encoder_turn_limit);
   assign clear_req = fault_clear_command | alarm_reset_key;

   // ==================================================
   // turn-limit write function
   always @* begin
      next_state = state;
      next_done_cnt = done_cnt;
      next_write_data = encoder_write_data;
      next_write_req = encoder_write_req;
      next_write_done = write_done;
      next_write_noop = 1'b0;
      case (state)
         ST_IDLE: begin
            // a request outside idle is dropped, not queued
            if (turn_limit_write_function) begin
               if (write_protect_setting == `DSAO_PROTECT_ON) begin
                  next_write_noop = 1'b1;
               end else begin
                  next_write_data = turn_limit_param;
                  next_write_req = 1'b1;
                  next_state = ST_WRITE;
               end
            end
         end
         ST_WRITE: begin
            if (encoder_write_ack) begin
               next_write_req = 1'b0;
               next_write_done = 1'b1;
               next_done_cnt = DONE_LAST;
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // done stands for exactly DONE_CYCLES enabled cycles
            if (done_cnt == 32'h00000000) begin
               next_write_done = 1'b0;
               next_state = ST_IDLE;
            end else begin
               next_done_cnt = done_cnt - 32'h00000001;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_write_req = 1'b0;
            next_write_done = 1'b0;
         end
      endcase
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         done_cnt <= 32'h00000000;
         encoder_write_req <= 1'b0;
         encoder_write_data <= 16'h0000;
         write_done <= 1'b0;
         write_noop <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         done_cnt <= next_done_cnt;
         encoder_write_req <= next_write_req;
         encoder_write_data <= next_write_data;
         write_done <= next_write_done;
         write_noop <= next_write_noop;
      end
   end

   // ==================================================
   // alarm latch and fault output; a clear with the cause still present
   // re-latches at once, so set wins over clear
   always @* begin
      next_latched = error_latched;
      if (mismatch || other_error)
         next_latched = 1'b1;
      else if (clear_req)
         next_latched = 1'b0;
      // high = open = alarm; a clear shows on the fault pin one cycle later
      next_fault = mismatch | other_error | error_latched;
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         error_latched <= 1'b0;
         turn_limit_mismatch_alarm <= 1'b0;
         fault_output <= 1'b0;
      end else if (ce) begin
         turn_limit_mismatch_alarm <= mismatch;
         error_latched <= next_latched;
         fault_output <= next_fault;
      end
   end

   // ==================================================
   // origin offset and machine coordinate
   // an out-of-range offset falls back to zero so a bad setting cannot wrap the position
   assign offset_ok = (origin_offset <= `DSAO_OFFSET_MAX) && (origin_offset >= -`DSAO_OFFSET_MAX);
   assign offset_eff = offset_ok ? origin_offset : `DSAO_OFFSET_DEF;
   always @* begin
      if (offset_applied)
         next_coord = encoder_position - offset_eff;
      else
         next_coord = encoder_position;
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         offset_applied <= 1'b0;
         machine_coord_position <= 32'sh00000000;
      end else if (ce) begin
         if (sensor_on_command)
            offset_applied <= 1'b1;
         machine_coord_position <= next_coord;
      end
   end

   // ==================================================
   // motion detect, level clamped to its legal range
   assign level_eff = (motion_detect_level < `DSAO_LEVEL_MIN) ? `DSAO_LEVEL_MIN :
                      (motion_detect_level > `DSAO_LEVEL_MAX) ? `DSAO_LEVEL_MAX :
                      motion_detect_level;
   // the level is read live, so a new setting takes effect on the next cycle
   always @* motion_level = (motor_speed >= level_eff);
   // each router registers its pins, so every pin leaves a flip-flop

   dsao_pin_route #(.PINS(PINS), .SELW(4)) u_caution (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .level(warning_condition),
      .sel(caution_pin_assign),
      .pins(caution_pins)
   );
   dsao_pin_route #(.PINS(PINS), .SELW(4)) u_motion (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .level(motion_level),
      .sel(motion_pin_assign),
      .pins(motion_pins)
   );
endmodule // dsao_status

//--- src/dsao_defs.vh
// constants for the drive status and alarm output block
// assumes a single 20 MHz clock and plain-port configuration
// Summary of operation
// - raise turn-limit mismatch alarm whenever stored limit differs from encoder limit
// - fault output off (high) while the mismatch alarm is active
// - write function copies limit to encoder, shows done for one second
// - write-protect value 0001 refuses the write function and reports no-operation
// - origin offset, signed, default 0, applied only after sensor-on command
// - encoder position equal to the origin offset maps to machine coordinate zero
// - fault output closed while normal, open on any error
// - latched alarm cleared by clear command or panel alarm reset key
// - warning output closed while a warning condition exists, open otherwise
// - warning output routed to the pin chosen by its allocation field
// - motion-detect closed when speed at or above level, open below
// - motion-detect level 1 to 10000 rpm, default 20, immediate effect
// - motion-detect output routed to the pin chosen by its allocation field
// - turn limit 0 to 65535 revolutions, default 65535, taken after restart
`ifndef DSAO_DEFS_VH
`define DSAO_DEFS_VH
`define DSAO_CLK_HZ 20000000
`define DSAO_DONE_TIME_MS 1000
`define DSAO_DONE_CYCLES ((`DSAO_CLK_HZ / 1000) * `DSAO_DONE_TIME_MS)
`define DSAO_PROTECT_ON 16'h0001
`define DSAO_LIMIT_DEF 16'hffff
`define DSAO_LEVEL_MIN 14'h0001
`define DSAO_LEVEL_MAX 14'h2710
`define DSAO_LEVEL_DEF 14'h0014
`define DSAO_OFFSET_MAX 32'sh3fffffff
`define DSAO_OFFSET_DEF 32'h00000000
`endif

//--- src/dsao_pin_route.v
// one-hot router placing a status level onto one of several output pins
// assumes the selector comes from same-clock logic; registered result
`timescale 1ns/10ps
module dsao_pin_route #(
   parameter PINS = 3,
   parameter SELW = 4
) (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire level,
   input wire [SELW-1:0] sel,
   output reg [PINS-1:0] pins
);
   integer i;
   reg [PINS-1:0] next_pins;
   // selector 0 means not allocated; 1..PINS pick a pin
   always @* begin
      next_pins = {PINS{1'b0}};
      for (i = 0; i < PINS; i = i + 1) begin
         if (sel == i[SELW-1:0] + 1'b1)
            next_pins[i] = level;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         pins <= {PINS{1'b0}};
      else if (ce)
         pins <= next_pins;
   end
endmodule // dsao_pin_route

//--- testbench/dsao_status_properties.sv
// port assertions for the status block
// assumes ce stays high while checked
`timescale 1ns/10ps
module dsao_status_properties #(parameter PINS = 3, parameter DONE_CYCLES = 5) (
   input logic clk, rst_n, ce, other_error, warning_condition, sensor_on_command,
   input logic encoder_write_ack, turn_limit_mismatch_alarm, fault_output, encoder_write_req,
   input logic write_done, write_noop, offset_applied, error_latched,
   input logic [15:0] write_protect_setting,
   input logic [13:0] motion_detect_level, motor_speed,
   input logic [3:0] caution_pin_assign, motion_pin_assign,
   input logic [PINS-1:0] caution_pins, motion_pins);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   int len;
   // speed of 0 left out: a level of 0 is clamped to 1
   wire fast = ce && motion_pin_assign == 4'h1 && motor_speed != 14'h0
      && motor_speed >= motion_detect_level;
   wire warn = ce && warning_condition && caution_pin_assign == 4'h2;
   always @(posedge clk or negedge rst_n) len <= !rst_n ? 0 : write_done ? len + 1 : 0;
   sequence ack_taken; ce && encoder_write_req && encoder_write_ack; endsequence
   sequence done_shown; write_done && !encoder_write_req; endsequence
   mismatch_opens_a: assert property ($rose(turn_limit_mismatch_alarm) |-> ##[0:1] fault_output)
      else $error("fault not open");
   error_latch_a: assert property (ce && other_error |=> error_latched && fault_output)
      else $error("error not latched");
   noop_protect_a: assert property (write_noop |-> $past(write_protect_setting) == 16'h0001)
      else $error("noop without protect");
   req_holds_a: assert property (encoder_write_req && !encoder_write_ack |=> encoder_write_req)
      else $error("request dropped");
   done_after_ack_a: assert property (ack_taken |=> done_shown)
      else $error("no done after ack");
   done_length_a: assert property ($fell(write_done) |-> len == DONE_CYCLES)
      else $error("done length wrong");
   motion_closes_a: assert property (fast |-> ##[1:2] motion_pins[0])
      else $error("motion pin open");
   caution_closes_a: assert property (warn |-> ##[1:2] caution_pins[1])
      else $error("caution pin open");
   offset_cause_a: assert property ($rose(offset_applied) |-> $past(sensor_on_command))
      else $error("offset without sensor on");
endmodule // dsao_status_properties
bind dsao_status dsao_status_properties #(.PINS(PINS), .DONE_CYCLES(DONE_CYCLES)) chk_i (.clk,
   .rst_n, .ce, .other_error, .warning_condition, .sensor_on_command, .encoder_write_ack,
   .turn_limit_mismatch_alarm, .fault_output, .encoder_write_req, .write_done, .write_noop,
   .offset_applied, .error_latched, .write_protect_setting, .motion_detect_level,
   .motor_speed, .caution_pin_assign, .motion_pin_assign, .caution_pins, .motion_pins);

//--- testbench/dsao_enc_model.sv
// encoder model: holds the stored turn limit, acks a write after DELAY cycles
// assumes the request holds until ack
`timescale 1ns/10ps
module dsao_enc_model #(parameter DELAY = 3) (
   input wire clk, rst_n, req,
   input wire [15:0] data,
   output reg ack,
   output reg [15:0] limit = 16'hffff);
   int cnt;
   // limit has no reset: the encoder keeps it across a power cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'h0;
         cnt <= 0;
      end else begin
         ack <= req && !ack && cnt == DELAY - 1;
         cnt <= req && !ack ? cnt + 1 : 0;
         if (req && !ack && cnt == DELAY - 1) limit <= data;
      end
   end
endmodule // dsao_enc_model

//--- testbench/dsao_status_tb.sv
// bench for the status block, host stimulus at the falling edge
// assumes the encoder model on the write port
`timescale 1ns/10ps
module dsao_status_tb;
   logic clk = 1'h0, rst_n = 1'h0, ce = 1'h1, turn_limit_write_function = 1'h0;
   logic sensor_on_command = 1'h0, other_error = 1'h0, warning_condition = 1'h0;
   logic fault_clear_command = 1'h0, alarm_reset_key = 1'h0, encoder_write_ack;
   logic turn_limit_mismatch_alarm, fault_output, encoder_write_req, write_done, write_noop;
   logic offset_applied, error_latched;
   logic [15:0] turn_limit_param = 16'h0063, write_protect_setting = 16'h0000;
   logic [15:0] encoder_turn_limit, encoder_write_data;
   logic signed [31:0] origin_offset = 32'sh0, encoder_position = 32'sh0, machine_coord_position;
   logic [13:0] motion_detect_level = 14'h0014, motor_speed = 14'h0000;
   logic [3:0] caution_pin_assign = 4'h2, motion_pin_assign = 4'h1;
   logic [2:0] caution_pins, motion_pins;
   int num_errors = 0, tests_run = 0, cycles = 0, i, n;
   dsao_status #(.DONE_CYCLES(5)) dut (.clk, .rst_n, .ce, .turn_limit_param, .encoder_turn_limit,
      .write_protect_setting, .turn_limit_write_function, .encoder_write_ack, .origin_offset,
      .encoder_position, .sensor_on_command, .other_error, .warning_condition,
      .fault_clear_command, .alarm_reset_key, .motion_detect_level, .motor_speed,
      .caution_pin_assign, .motion_pin_assign, .turn_limit_mismatch_alarm, .fault_output,
      .encoder_write_data, .encoder_write_req, .write_done, .write_noop,
      .machine_coord_position, .offset_applied, .error_latched, .caution_pins, .motion_pins);
   dsao_enc_model enc (.clk, .rst_n, .req(encoder_write_req), .data(encoder_write_data),
      .ack(encoder_write_ack), .limit(encoder_turn_limit));
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task end_of_test;
      if (num_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task settle;
      repeat (3) @(negedge clk);
   endtask
   task restart;
      rst_n = 1'h0;
      repeat (12) @(negedge clk);
      rst_n = 1'h1;
      settle;
   endtask
   task pulse_write;
      turn_limit_write_function = 1'h1;
      @(negedge clk);
      turn_limit_write_function = 1'h0;
   endtask
   task t_protect;
      write_protect_setting = 16'h0001;
      pulse_write;
      chk("noop", 1'h1, write_noop);
      @(negedge clk);
      chk("req", 1'h0, encoder_write_req);
      write_protect_setting = 16'h0000;
   endtask
   task t_write;
      chk("alarm", 1'h1, turn_limit_mismatch_alarm);
      chk("fault", 1'h1, fault_output);
      pulse_write;
      chk("data", 16'h0063, encoder_write_data);
      for (i = 0; i < 30 && write_done !== 1'h1; i++) @(negedge clk);
      for (n = 0; n < 20 && write_done === 1'h1; n++) @(negedge clk);
      chk("done len", 32'h5, n);
      restart;
      chk("alarm", 1'h0, turn_limit_mismatch_alarm);
      turn_limit_param = 16'h0010;
      settle;
      chk("alarm", 1'h0, turn_limit_mismatch_alarm);
      restart;
      chk("alarm", 1'h1, turn_limit_mismatch_alarm);
      turn_limit_param = 16'h0063;
      restart;
   endtask
   task t_latch;
      for (i = 0; i < 2; i++) begin
         other_error = 1'h1;
         @(negedge clk);
         other_error = 1'h0;
         @(negedge clk);
         chk("fault", 1'h1, fault_output);
         {alarm_reset_key, fault_clear_command} = i ? 2'h2 : 2'h1;
         @(negedge clk);
         {alarm_reset_key, fault_clear_command} = 2'h0;
         @(negedge clk);
         chk("latch", 1'h0, error_latched);
         chk("fault", 1'h0, fault_output);
      end
      ce = 1'h0;
      other_error = 1'h1;
      settle;
      chk("frozen", 1'h0, error_latched);
      other_error = 1'h0;
      ce = 1'h1;
      settle;
   endtask
   task t_pins;
      for (i = 0; i < 3; i++) begin
         motor_speed = 14'h0013 + i[13:0];
         settle;
         chk("motion", i ? 3'h1 : 3'h0, motion_pins);
      end
      motion_detect_level = 14'h0016;
      settle;
      chk("motion", 3'h0, motion_pins);
      motion_pin_assign = 4'h3;
      motion_detect_level = 14'h0001;
      warning_condition = 1'h1;
      settle;
      chk("motion", 3'h4, motion_pins);
      chk("caution", 3'h2, caution_pins);
      caution_pin_assign = 4'h1;
      settle;
      chk("caution", 3'h1, caution_pins);
   endtask
   task t_offset;
      origin_offset = 32'sh100;
      encoder_position = 32'sh100;
      settle;
      chk("applied", 1'h0, offset_applied);
      chk("coord", 32'h100, machine_coord_position);
      sensor_on_command = 1'h1;
      @(negedge clk);
      sensor_on_command = 1'h0;
      settle;
      chk("coord", 32'h0, machine_coord_position);
      encoder_position = 32'sh180;
      settle;
      chk("coord", 32'h80, machine_coord_position);
   endtask
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         end_of_test;
      end
   end
   initial begin
      restart;
      t_protect;
      t_write;
      t_latch;
      t_pins;
      t_offset;
      end_of_test;
   end
endmodule // dsao_status_tb
